/* File: sse_i2c_master.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Serial bus master model: open-drain SDA, SCL stands high between frames
module sse_i2c_master (
  output logic scl,     // Serial clock, master owned
  output logic sdaLow,  // High pulls SDA low
  input  wire  sda      // Resolved SDA wire
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end
  // Data moves mid-low so it never changes while SCL is high
  task automatic bitx(input logic b, output logic r);
    #12 sdaLow = !b;
    #12 scl = 1'h1;
    #12 r = sda;
    #12 scl = 1'h0;
  endtask
  // Also serves as repeated start; ird issues one before its read phase
  task automatic start();
    #12 sdaLow = 1'h0;
    #12 scl = 1'h1;
    #12 sdaLow = 1'h1;
    #12 scl = 1'h0;
  endtask
  // Every operation is closed with a stop
  task automatic stop();
    #12 sdaLow = 1'h1;
    #12 scl = 1'h1;
    #12 sdaLow = 1'h0;
    #12;
  endtask
  // Byte out, MSB first, then sample the ninth-clock acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'h1, r);
    ack = !r;
  endtask
  // Byte in; acknowledge to continue, release on the last one
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'h1, d[i]);
    bitx(last, r);
  endtask
endmodule

/* File: sse_pkg.sv */
package sse_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (AHB-Lite, byte addresses, one word each)
  localparam logic [7:0] SSE_CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] SSE_STATUS_OFFSET = 8'h04;

  // Control fields
  localparam int         SSE_THRESH_LSB    = 0;
  localparam int         SSE_THRESH_W      = 3;
  localparam logic [2:0] SSE_THRESH_RESET  = 3'h0;
  localparam logic [2:0] SSE_THRESH_COUNT  = 3'h5;

  // Status fields
  localparam int         SSE_ST_RESET_BIT  = 0;
  localparam int         SSE_ST_BUSY_BIT   = 1;
  localparam int         SSE_ST_SUPPLY_BIT = 2;
  localparam int         SSE_ST_WP_BIT     = 3;
  localparam int         SSE_ST_BUS_BIT    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: free-running 1 us timebase derived from the 200 MHz clock
  localparam int         SSE_CLK_PERIOD_PS    = 5000;
  localparam int         SSE_TICK_NS          = 1000;
  localparam logic [7:0] SSE_TICK_CYCLES      = 8'(SSE_TICK_NS * 1000 / SSE_CLK_PERIOD_PS);
  localparam int         SSE_RESET_TIMEOUT_MS = 200;
  localparam int unsigned SSE_RESET_TICKS     = SSE_RESET_TIMEOUT_MS * 1000000 / SSE_TICK_NS;
  localparam int         SSE_WRITE_CYCLE_MS   = 10;
  localparam int unsigned SSE_WRITE_TICKS     = SSE_WRITE_CYCLE_MS * 1000000 / SSE_TICK_NS;
  localparam int         SSE_WATCHDOG_MS      = 1600;
  localparam int unsigned SSE_WATCHDOG_TICKS  = SSE_WATCHDOG_MS * 1000000 / SSE_TICK_NS;
  localparam int         SSE_POWER_UP_TO_READ_DELAY_MS = 1;
  localparam int         SSE_THRESHOLD_TO_RESET_DELAY_US = 5;
  localparam int         SSE_THRESH_TO_RESET_CYC =
                         SSE_THRESHOLD_TO_RESET_DELAY_US * 1000000 / SSE_CLK_PERIOD_PS;
  localparam logic [3:0] SSE_BLANK_CYCLES     = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Serial bus
  localparam logic [3:0] SSE_DEV_PATTERN = 4'hA;
  localparam int         SSE_PAGE_BITS   = 4;
  localparam logic [3:0] SSE_BIT_LAST    = 4'h7;
  localparam logic [3:0] SSE_BIT_ACK     = 4'h8;

  typedef enum logic [2:0] {
    SSE_IDLE,
    SSE_DEV,
    SSE_WORD,
    SSE_WRITE,
    SSE_READ,
    SSE_STOPWAIT
  } sse_bus_state_type;

endpackage

/* File: sse_top.sv */
`timescale 1ns/10ps
// Behaviour
// R1: Master waits 1 ms after supply stable
// R2: Write cycle at most 10 ms, bus ignored
// R3: Power-up reset held past threshold, ~200 ms
// R4: Reset pins released after timeout expires
// R5: Supply drop drives resets within 5 us
// R6: External reset starts ~200 ms reset timeout
// R7: Reset pins sensed by level
// R8: Watchdog fires after 1.6 s without kick
// R9: Any kick edge clears watchdog count
// R10: Watchdog held cleared during reset
// R11: Protect pin high makes array read-only
// R12: Writes inhibited while supply below threshold
// R13: Threshold option kept, one of five
// R14: Master makes clock, start and stop
// R15: SDA change with SCL high is start/stop
// R16: Start is SDA fall, SCL high; else ignore
// R17: Stop is SDA rise, SCL high; ends transaction
// R18: Master starts only on idle bus
// R19: Respond only to address pattern 1010
// R20: Three address bits used per density
// R21: Address LSB selects read or write
// R22: Acknowledge matching address, then do operation
// R23: SDA driven open-drain only
// R24: Receiver acknowledges on ninth clock
// R25: Page write wraps within 16 bytes
// R26: Protected: no ack after first data byte
// R27: Address counter holds last address plus one
// R28: Timeouts counted on free-running internal timebase
// R29: Supply and reset pins synchronised first
module sse_top
  import sse_pkg::*;
#(
  parameter int          ADDR_W         = 11,
  parameter int unsigned RESET_TICKS    = SSE_RESET_TICKS,
  parameter int unsigned WRITE_TICKS    = SSE_WRITE_TICKS,
  parameter int unsigned WATCHDOG_TICKS = SSE_WATCHDOG_TICKS,
  parameter logic [2:0]  THRESH_INIT    = SSE_THRESH_RESET
) (
  input  logic        ref_clk,          // System clock
  input  logic        reset_n,          // Synchronous reset
  input  logic        hsel,             // AHB select
  input  logic [31:0] haddr,            // AHB address
  input  logic [1:0]  htrans,           // AHB transfer type
  input  logic        hwrite,           // AHB write
  input  logic [2:0]  hsize,            // AHB size
  input  logic [31:0] hwdata,           // AHB write data
  input  logic        hready,           // AHB bus ready
  output logic        hreadyout,        // AHB slave ready
  output logic [31:0] hrdata,           // AHB read data
  output logic        hresp,            // AHB response
  input  logic        sclIn,            // Serial clock pin
  input  logic        sdaIn,            // Serial data pin level
  output logic        sdaOut,           // Serial data drive value
  output logic        sdaOe,            // Serial data pull-down enable
  input  logic        supplyOkIn,       // Comparator: supply above threshold
  output logic [2:0]  thresholdSelOut,  // Selected threshold option
  input  logic        rstHighIn,        // Active-high reset pin level
  output logic        rstHighOut,       // Active-high reset drive value
  output logic        rstHighOe,        // Active-high reset drive enable
  input  logic        rstLowIn,         // Active-low reset pin level
  output logic        rstLowOut,        // Active-low reset drive value
  output logic        rstLowOe,         // Active-low reset drive enable
  input  logic        watchdogKickIn,   // Watchdog kick pin
  input  logic        writeProtectIn    // Write protect pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic              sclM, sclS, sclP, sdaM, sdaS, sdaP;
  logic              supM, supplyS, wpM, wpS, kickM, kickS, kickP;
  logic              rhM, rstHighS, rlM, rstLowS;
  logic              sclRise, sclFall, startDet, stopDet, kickEdge, tick;
  logic [7:0]        tickCntQ;
  logic              rstActQ;
  logic [31:0]       rstCntQ, wdCntQ, wrCntQ;
  logic [3:0]        blankQ;
  logic              extActive, wdTimeout, rstTrig, busyQ;
  sse_bus_state_type stateQ;
  logic [3:0]        bitCntQ;
  logic [7:0]        shiftQ, txQ, rdByte;
  logic              sdaOeQ, rwQ, masterAckQ, wrotePendQ, armQ;
  logic [2:0]        hiAddrQ;
  logic [ADDR_W-1:0] addrQ;
  logic [7:0]        memQ [0:(1 << ADDR_W) - 1];
  logic              addrMatch, writeOk, ackNow, byteEnd, memWe;
  logic              ahbWrQ;
  logic [7:0]        ahbAddrQ;
  logic [31:0]       readMux, hrdataQ;
  logic [2:0]        threshQ;
  int unsigned       lowCycQ;

  // Upper address bits from the slave byte, trimmed to the array size
  function automatic logic [ADDR_W-1:0] fullAddr(input logic [2:0] hi, input logic [7:0] lo);
    logic [10:0] full;
    full = {hi, lo};
    return full[ADDR_W-1:0];
  endfunction

  // Next address inside the same 16-byte page
  function automatic logic [ADDR_W-1:0] pageInc(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:SSE_PAGE_BITS], a[SSE_PAGE_BITS-1:0] + 4'h1};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      {sclM, sclS, sclP} <= 3'h7;
      {sdaM, sdaS, sdaP} <= 3'h7;
      {supM, supplyS}    <= 2'h0;
      {wpM, wpS}         <= 2'h0;
      {kickM, kickS, kickP} <= 3'h0;
      {rhM, rstHighS}    <= 2'h0;
      {rlM, rstLowS}     <= 2'h3;
    end else begin
      {sclM, sclS, sclP} <= {sclIn, sclM, sclS};
      {sdaM, sdaS, sdaP} <= {sdaIn, sdaM, sdaS};
      {supM, supplyS}    <= {supplyOkIn, supM};         // R29
      {wpM, wpS}         <= {writeProtectIn, wpM};
      {kickM, kickS, kickP} <= {watchdogKickIn, kickM, kickS};
      {rhM, rstHighS}    <= {rstHighIn, rhM};           // R29
      {rlM, rstLowS}     <= {rstLowIn, rlM};            // R29
    end
  end

  // Edge and condition detection, only on settled stages
  assign sclRise  = sclS && !sclP;
  assign sclFall  = !sclS && sclP;
  assign startDet = sclS && sclP && sdaP && !sdaS;      // R15 R16
  assign stopDet  = sclS && sclP && !sdaP && sdaS;      // R15 R17
  assign kickEdge = kickS ^ kickP;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 1 us timebase; the bus clock never paces timeouts
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tickCntQ <= 8'h00;
    end else if (tick) begin
      tickCntQ <= 8'h00;
    end else begin
      tickCntQ <= tickCntQ + 8'h01;
    end
  end
  assign tick = (tickCntQ == SSE_TICK_CYCLES - 8'h01);  // R28

  ////////////////////////////////////////////////////////////////////////////
  // Reset generator; triggers restart the timeout and hold it at zero
  assign extActive = !rstActQ && (blankQ == 4'h0) && (rstHighS || !rstLowS); // R7
  assign wdTimeout = (wdCntQ >= WATCHDOG_TICKS);
  assign rstTrig   = !supplyS || extActive || wdTimeout;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rstActQ <= 1'b1;                                   // R3
      rstCntQ <= 32'h0000_0000;
    end else if (rstTrig) begin
      rstActQ <= 1'b1;                                   // R5 R6 R8
      rstCntQ <= 32'h0000_0000;
    end else if (rstActQ && tick) begin
      if (rstCntQ == RESET_TICKS - 1) begin
        rstActQ <= 1'b0;                                 // R3 R4
        rstCntQ <= 32'h0000_0000;
      end else begin
        rstCntQ <= rstCntQ + 32'h0000_0001;              // R28
      end
    end
  end

  // Blank pin sensing briefly after release, while the pulls restore the level
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      blankQ <= SSE_BLANK_CYCLES;
    end else if (rstActQ) begin
      blankQ <= SSE_BLANK_CYCLES;
    end else if (blankQ != 4'h0) begin
      blankQ <= blankQ - 4'h1;
    end
  end

  // Open-drain reset pins: only ever drive the active level
  assign rstHighOut = 1'b1;
  assign rstHighOe  = rstActQ;                           // R4
  assign rstLowOut  = 1'b0;
  assign rstLowOe   = rstActQ;                           // R4

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wdCntQ <= 32'h0000_0000;
    end else if (rstActQ || kickEdge) begin
      wdCntQ <= 32'h0000_0000;                           // R9 R10
    end else if (tick) begin
      wdCntQ <= wdCntQ + 32'h0000_0001;                  // R8 R28
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write cycle after a stop that ends a write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busyQ  <= 1'b0;
      wrCntQ <= 32'h0000_0000;
    end else if (!busyQ) begin
      busyQ  <= stopDet && wrotePendQ;                   // R2
      wrCntQ <= 32'h0000_0000;
    end else if (tick) begin
      if (wrCntQ == WRITE_TICKS - 1) begin
        busyQ <= 1'b0;                                   // R2 R28
      end else begin
        wrCntQ <= wrCntQ + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave engine
  assign addrMatch = (shiftQ[7:4] == SSE_DEV_PATTERN);  // R19
  assign writeOk   = !wpS && supplyS;                    // R11 R12
  assign ackNow    = (stateQ == SSE_DEV)   ? addrMatch :
                     (stateQ == SSE_WRITE) ? writeOk : 1'b1;
  assign byteEnd   = sclFall && (bitCntQ == SSE_BIT_LAST) && !busyQ && !startDet && !stopDet;
  assign memWe     = byteEnd && (stateQ == SSE_WRITE) && writeOk;
  assign rdByte    = memQ[addrQ];

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stateQ     <= SSE_IDLE;
      bitCntQ    <= 4'h0;
      shiftQ     <= 8'h00;
      txQ        <= 8'h00;
      sdaOeQ     <= 1'b0;
      rwQ        <= 1'b0;
      hiAddrQ    <= 3'h0;
      addrQ      <= '0;
      masterAckQ <= 1'b0;
      wrotePendQ <= 1'b0;
      armQ       <= 1'b0;
    end else if (busyQ) begin
      stateQ     <= SSE_IDLE;                            // R2
      sdaOeQ     <= 1'b0;
      wrotePendQ <= 1'b0;
    end else if (startDet) begin
      stateQ  <= SSE_DEV;                                // R16
      bitCntQ <= 4'h0;
      armQ    <= 1'b0;
      sdaOeQ  <= 1'b0;
    end else if (stopDet) begin
      stateQ  <= SSE_IDLE;                               // R17
      sdaOeQ  <= 1'b0;
    end else begin
      if (sclRise) begin
        armQ <= 1'b1;
        if (bitCntQ != SSE_BIT_ACK) begin
          shiftQ <= {shiftQ[6:0], sdaS};
        end else begin
          masterAckQ <= !sdaS;
        end
      end
      // The fall that closes a start carries no bit, so it must not count
      if (sclFall && armQ) begin                         // R24
        unique case (stateQ)
          SSE_IDLE, SSE_STOPWAIT: begin
            sdaOeQ <= 1'b0;
          end
          SSE_DEV, SSE_WORD, SSE_WRITE: begin
            if (bitCntQ < SSE_BIT_LAST) begin
              bitCntQ <= bitCntQ + 4'h1;
            end else if (bitCntQ == SSE_BIT_LAST) begin
              bitCntQ <= SSE_BIT_ACK;
              sdaOeQ  <= ackNow;                         // R22 R24 R26
              if (stateQ == SSE_DEV) begin
                rwQ     <= shiftQ[0];                    // R21
                hiAddrQ <= shiftQ[3:1];                  // R20
                if (!addrMatch) begin
                  stateQ <= SSE_IDLE;                    // R19
                end
              end else if (stateQ == SSE_WORD) begin
                addrQ <= fullAddr(hiAddrQ, shiftQ);      // R20
              end else if (writeOk) begin
                addrQ      <= pageInc(addrQ);            // R25 R27
                wrotePendQ <= 1'b1;
              end else begin
                stateQ <= SSE_STOPWAIT;                  // R26
              end
            end else begin
              bitCntQ <= 4'h0;
              if (stateQ == SSE_DEV && rwQ) begin
                stateQ <= SSE_READ;                      // R22
                txQ    <= rdByte;
                sdaOeQ <= !rdByte[7];
                addrQ  <= addrQ + ADDR_W'(1);            // R27
              end else begin
                stateQ <= (stateQ == SSE_DEV) ? SSE_WORD : SSE_WRITE;
                sdaOeQ <= 1'b0;
              end
            end
          end
          SSE_READ: begin
            if (bitCntQ < SSE_BIT_LAST) begin
              txQ     <= {txQ[6:0], 1'b0};
              sdaOeQ  <= !txQ[6];
              bitCntQ <= bitCntQ + 4'h1;
            end else if (bitCntQ == SSE_BIT_LAST) begin
              sdaOeQ  <= 1'b0;                           // R24
              bitCntQ <= SSE_BIT_ACK;
            end else begin
              bitCntQ <= 4'h0;
              if (masterAckQ) begin
                txQ    <= rdByte;
                sdaOeQ <= !rdByte[7];
                addrQ  <= addrQ + ADDR_W'(1);            // R27
              end else begin
                stateQ <= SSE_STOPWAIT;
              end
            end
          end
        endcase
      end
    end
  end

  // Array storage; written byte by byte as each data byte is accepted
  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      memQ[addrQ] <= shiftQ;                             // R11 R12
    end
  end

  // SDA is only ever pulled low or released, so it can share the wire
  assign sdaOut = 1'b0;                                  // R23
  assign sdaOe  = sdaOeQ;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, unmapped words read zero
  always_comb begin
    readMux = 32'h0000_0000;
    unique case (haddr[7:0])
      SSE_CTRL_OFFSET: begin
        readMux[SSE_THRESH_LSB +: SSE_THRESH_W] = threshQ;
      end
      SSE_STATUS_OFFSET: begin
        readMux[SSE_ST_RESET_BIT]  = rstActQ;
        readMux[SSE_ST_BUSY_BIT]   = busyQ;
        readMux[SSE_ST_SUPPLY_BIT] = supplyS;
        readMux[SSE_ST_WP_BIT]     = wpS;
        readMux[SSE_ST_BUS_BIT]    = (stateQ != SSE_IDLE);
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ahbWrQ   <= 1'b0;
      ahbAddrQ <= 8'h00;
      hrdataQ  <= 32'h0000_0000;
    end else if (hready) begin
      ahbWrQ   <= hsel && htrans[1] && hwrite;
      ahbAddrQ <= haddr[7:0];
      hrdataQ  <= (hsel && htrans[1] && !hwrite) ? readMux : 32'h0000_0000;
    end
  end

  // Threshold option; out-of-range codes are ignored so the choice stays legal
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      threshQ <= THRESH_INIT;                            // R13
    end else if (ahbWrQ && ahbAddrQ == SSE_CTRL_OFFSET &&
                 hwdata[SSE_THRESH_LSB +: SSE_THRESH_W] < SSE_THRESH_COUNT) begin
      threshQ <= hwdata[SSE_THRESH_LSB +: SSE_THRESH_W]; // R13
    end
  end

  assign thresholdSelOut = threshQ;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = hrdataQ;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Cycles of low supply without driven resets
  always_ff @(posedge ref_clk) begin
    if (!reset_n || supplyS || rstLowOe) begin
      lowCycQ <= 0;
    end else begin
      lowCycQ <= lowCycQ + 1;
    end
  end

  busyQuiet_a: assert property (busyQ |-> !sdaOe) // R2
    else $error("SDA pulled during write cycle");
  writeLen_a: assert property (busyQ |-> wrCntQ < WRITE_TICKS) // R2
    else $error("Write cycle overran its limit");
  pwrHold_a: assert property (!supplyS |=> rstActQ && rstCntQ == 32'h0000_0000) // R3
    else $error("Reset not held while supply low");
  rstRelease_a: assert property ($fell(rstActQ) |-> $past(rstCntQ) == RESET_TICKS - 1) // R4
    else $error("Reset released before timeout");
  brownDelay_a: assert property (lowCycQ < SSE_THRESH_TO_RESET_CYC) // R5
    else $error("Reset late after supply drop");
  supplyDrop_a: assert property ($fell(supplyS) |=> (rstLowOe && rstHighOe)[*2]) // R5
    else $error("Reset pins not driven on supply drop");
  extTrig_a: assert property (extActive |=> rstActQ && rstHighOe && rstLowOe) // R6
    else $error("External reset level not honoured");
  wdFire_a: assert property (wdCntQ >= WATCHDOG_TICKS |=> rstActQ) // R8
    else $error("Watchdog timeout gave no reset");
  wdClear_a: assert property (kickEdge |=> wdCntQ == 32'h0000_0000) // R9
    else $error("Kick edge did not clear watchdog");
  wdHold_a: assert property (rstActQ ##1 rstActQ |=>
                             $stable(wdCntQ) && wdCntQ == 32'h0000_0000) // R10
    else $error("Watchdog counted during reset");
  wpGuard_a: assert property (memWe |-> !wpS && supplyS) // R11
    else $error("Array written while inhibited");
  idleWait_a: assert property (stateQ == SSE_IDLE && !startDet |=> stateQ == SSE_IDLE) // R16
    else $error("Bus engine left idle without start");
  devAck_a: assert property (byteEnd && stateQ == SSE_DEV |=> sdaOeQ == $past(addrMatch)) // R19
    else $error("Address acknowledge wrong");
  pageWrap_a: assert property (memWe |=> addrQ[ADDR_W-1:SSE_PAGE_BITS] ==
                               $past(addrQ[ADDR_W-1:SSE_PAGE_BITS])) // R25
    else $error("Page write left its page");

endmodule

/* File: sse_top_tb_top.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Bench: reset monitor, watchdog, register port and serial memory
module sse_top_tb_top;
  import sse_pkg::*;
  logic        ref_clk, reset_n, hsel, hwrite, hreadyout, sdaOe, scl, mSdaLow, a;
  logic        supplyOk, wp, kick, kickEn, extHigh, extLow, rstHighOe, rstLowOe;
  logic        hresp, sdaOut, rstHighOut, rstLowOut;
  logic [1:0]  htrans;
  logic [2:0]  hsize, thr, acks;
  logic [7:0]  d, nx;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          errors, checked;
  // Open-drain wires: SDA pulled up, high reset pulled down, low reset pulled up
  wire         sda = !(sdaOe || mSdaLow);
  wire         rstHighIn = rstHighOe || extHigh;
  wire         rstLowIn = !(rstLowOe || extLow);
  ////////////////////////////////////////////////////////////////////////////////
  sse_top #(.RESET_TICKS(20), .WRITE_TICKS(10), .WATCHDOG_TICKS(50)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .supplyOkIn(supplyOk), .thresholdSelOut(thr),
    .rstHighIn(rstHighIn), .rstHighOut(rstHighOut), .rstHighOe(rstHighOe),
    .rstLowIn(rstLowIn), .rstLowOut(rstLowOut), .rstLowOe(rstLowOe),
    .watchdogKickIn(kick), .writeProtectIn(wp));
  sse_i2c_master m (.scl(scl), .sdaLow(mSdaLow), .sda(sda));
  // 200 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Kicks every 10 us, well inside the shortened watchdog span
  initial forever begin
    repeat (2000) @(posedge ref_clk);
    if (kickEn) kick <= ~kick;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait for hready; a hang ends the run as a mismatch
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    rdy();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    rdy();
    r = hrdata;
  endtask
  // Polls busy; the bound also caps the write cycle length
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      ahb(1'h0, SSE_STATUS_OFFSET, 32'h0, rd);
      n++;
    end while (rd[SSE_ST_BUSY_BIT] !== 1'h0 && n < 1300);
    check("write cycle ended", n < 1300, 1'h1);
  endtask
  task automatic rst_span(input string what);
    repeat (3400) @(posedge ref_clk);
    check(what, {rstHighOe, rstLowOe}, 2'h3);
    repeat (1200) @(posedge ref_clk);
    check(what, {rstHighIn, rstLowIn}, 2'h1);
  endtask
  task automatic iwr(input logic [7:0] dev, wa, input logic [23:0] dt, input int n);
    m.start();
    m.wbyte(dev, acks[2]);
    m.wbyte(wa, acks[1]);
    acks[0] = 1'h1;
    for (int i = 0; i < n; i++) begin
      m.wbyte(dt[23 - 8 * i -: 8], a);
      acks[0] = acks[0] & a;
    end
    m.stop();
  endtask
  // Random read of two bytes through a repeated start
  task automatic ird(input logic [7:0] dev, wa);
    m.start();
    m.wbyte(dev, a);
    m.wbyte(wa, a);
    m.start();
    m.wbyte(dev | 8'h01, a);
    m.rbyte(1'h0, d);
    m.rbyte(1'h1, nx);
    m.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    check("reset at release", {rstHighOe, rstLowOe}, 2'h3);
    repeat (6000) @(posedge ref_clk);
    check("reset supply low", {rstHighOe, rstLowOe}, 2'h3);
    supplyOk <= 1'h1;
    rst_span("power-up reset");
    $display("test power-up done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      ahb(1'h1, SSE_CTRL_OFFSET, i, rd);
      ahb(1'h0, SSE_CTRL_OFFSET, 32'h0, rd);
      check("threshold option", rd, (i < 5) ? i : 4);
    end
    check("threshold pins", thr, 3'h4);
    check("fixed drive levels", {hresp, sdaOut, rstHighOut, rstLowOut}, 4'h2);
    ahb(1'h0, 8'h08, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    ahb(1'h0, SSE_STATUS_OFFSET, 32'h0, rd);
    check("status", rd & 32'h5, 32'h4);
    $display("test registers done");
  endtask
  task automatic t_i2c();
    iwr(8'hA0, 8'h3F, 24'hC35A96, 3);
    check("page write acks", acks, 3'h7);
    m.start();
    m.wbyte(8'hA0, a);
    m.stop();
    check("ack while busy", a, 1'h0);
    wait_idle();
    iwr(8'hA2, 8'h3F, 24'h110000, 1);
    wait_idle();
    m.start();
    m.wbyte(8'hB0, a);
    m.stop();
    check("foreign address ack", a, 1'h0);
    ird(8'hA0, 8'h30);
    check("wrapped byte", d, 8'h5A);
    check("next byte", nx, 8'h96);
    ird(8'hA2, 8'h3F);
    check("upper bank byte", d, 8'h11);
    ird(8'hA0, 8'h3F);
    check("lower bank byte", d, 8'hC3);
    $display("test serial done");
  endtask
  task automatic t_inhibit();
    @(posedge ref_clk);
    wp <= 1'h1;
    iwr(8'hA0, 8'h30, 24'h0, 1);
    check("protected acks", acks, 3'h6);
    @(posedge ref_clk);
    wp <= 1'h0;
    supplyOk <= 1'h0;
    repeat (6) @(posedge ref_clk);
    check("reset on supply drop", {rstHighOe, rstLowOe}, 2'h3);
    iwr(8'hA0, 8'h30, 24'h0, 1);
    check("low supply data ack", acks[0], 1'h0);
    @(posedge ref_clk);
    supplyOk <= 1'h1;
    rst_span("supply return");
    ird(8'hA0, 8'h30);
    check("unchanged byte", d, 8'h5A);
    $display("test inhibit done");
  endtask
  task automatic t_ext();
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      {extHigh, extLow} <= i ? 2'h2 : 2'h1;
      repeat (8) @(posedge ref_clk);
      check("external reset", {rstHighOe, rstLowOe}, 2'h3);
      {extHigh, extLow} <= 2'h0;
      rst_span("external reset span");
    end
    $display("test external reset done");
  endtask
  task automatic t_watchdog();
    int n;
    @(kick);
    @(posedge ref_clk);
    kickEn <= 1'h0;
    repeat (9400) @(posedge ref_clk);
    check("watchdog early", {rstHighOe, rstLowOe}, 2'h0);
    n = 0;
    while (rstLowOe !== 1'h1 && n < 800) begin
      @(posedge ref_clk);
      n++;
    end
    check("watchdog fired", n < 800, 1'h1);
    rst_span("watchdog reset");
    repeat (8000) @(posedge ref_clk);
    check("watchdog held in reset", {rstHighOe, rstLowOe}, 2'h0);
    $display("test watchdog done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; supply starts below threshold
  initial begin
    {reset_n, hsel, hwrite, supplyOk, wp, kick, extHigh, extLow} = 8'h0;
    {htrans, haddr, hwdata} = 66'h0;
    {errors, checked} = 64'h0;
    hsize = 3'h2;
    kickEn = 1'h1;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    t_power();
    t_regs();
    t_i2c();
    t_inhibit();
    t_ext();
    t_watchdog();
    end_of_test();
  end
endmodule
